// File: common/fwec_pkg.sv
// constants shared by the serial flash housekeeping command decoder
package fwec_pkg;
	// instruction codes
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_VOL_DIRECT = 8'h50;
	localparam logic [7:0] OP_STATUS_CLEAR = 8'h30;
	localparam logic [7:0] OP_PAT_NV_PROGRAM = 8'h43;
	localparam logic [7:0] OP_PAT_VOL_WRITE = 8'h4A;
	localparam logic [7:0] OP_PAT_READ = 8'h41;
	localparam logic [7:0] OP_ENTER_WIDE = 8'hB7;
	// field positions
	localparam int WIP_BIT = 0;
	localparam int WPL_BIT = 1;
	localparam int PERR_BIT = 5;
	localparam int EERR_BIT = 6;
	localparam int ALEN_BIT = 0;
	localparam int OUT_LANE = 1;
	// serial framing
	localparam logic [3:0] SINGLE_CLKS = 4'h8;
	localparam logic [3:0] QUAD_CLKS = 4'h2;
	localparam logic [3:0] LANES_ALL = 4'hF;
	localparam int SERIAL_MAX_MHZ = 133;
	// core clock
	localparam int CLK_PERIOD_PS = 4000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ARG = 3'b010,
		ST_EXEC = 3'b011,
		ST_RD_DUMMY = 3'b100,
		ST_RD_OUT = 3'b101,
		ST_DROP = 3'b110
	} fwec_state_t;
endpackage

// File: design/fwec_sync.sv
// two-stage synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
module fwec_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset
	input wire logic [W-1:0] d_i, // asynchronous inputs
	output logic [W-1:0] q_o // synchronised outputs
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} fwec_sync_t;

	fwec_sync_t q;
	fwec_sync_t next_q;

	always_comb
	begin
		next_q.meta = d_i;
		next_q.stable = q.meta;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= {RESET_VAL, RESET_VAL};
		end
		else
		begin
			q <= next_q;
		end
	end

	assign q_o = q.stable;
endmodule

// File: design/fwec_top.sv
// housekeeping command decoder: write latch, status clear, learning pattern, wide address
// Notes on behaviour
// - latch-set instruction sets the write permission latch in status one.
// - writes and pattern programs run only with the write permission latch set.
// - single-byte latch and volatile-direct commands need chip select raised right after byte.
// - latch-clear instruction clears the write permission latch.
// - latch-clear is ignored while write-in-progress reads one.
// - volatile-direct leaves the latch alone, marks next register write volatile.
// - status-clear zeroes write-in-progress, latch, program error and erase error.
// - status-clear needs no latch and is taken even while busy.
// - pattern program needs latch, one data byte, chip select raised right after it.
// - pattern program is self-timed with busy set; reports failure, clears latch at end.
// - volatile pattern write needs latch and one data byte; updates at once.
// - pattern read waits one dummy clock then repeats the 8-bit pattern.
// - data lines are ignored during the dummy clock.
// - enter-wide sets the address length bit, bit 0 of volatile config two.
// - exit or any-register write clears it; resets restore the non-volatile setting.
// - in four-line mode all bytes move four bits per clock.
// - latch-set targets register writes at non-volatile copies, volatile-direct at volatile.
// - failed register write keeps device busy with error until status-clear.
`timescale 1ns/1ps
module fwec_top
	import fwec_pkg::*;
#(
	parameter int PROG_TIME_NS = 1000
) (
	input wire logic MCLK_I, // core clock, 250 MHz
	input wire logic RESET_I, // synchronous reset, active high
	input wire logic SCK_I, // serial clock pin
	input wire logic CS_N_I, // chip select pin, active low
	input wire logic [3:0] IO_I, // data lines in, line 0 is serial_in_line0
	output logic [3:0] IO_O, // data lines out, line 1 is serial_out_line1
	output logic [3:0] IO_OE_O, // data line drive enables
	input wire logic FOUR_LINE_MODE_I, // four_line_command_mode selected
	input wire logic NV_ADDR_LEN_I, // non-volatile address length setting
	input wire logic SOFT_RESET_I, // software reset pulse
	input wire logic WIDE_ADDR_CLEAR_I, // exit-wide or any-register write clears length
	input wire logic REG_WRITE_DONE_I, // register write finished pulse
	input wire logic REG_WRITE_FAIL_I, // register write failed pulse
	input wire logic ERASE_FAIL_I, // erase failed pulse
	input wire logic PROG_FAIL_I, // pattern program failure level at completion
	output logic [7:0] STATUS_ONE_O, // volatile_status_one
	output logic [7:0] STATUS_TWO_O, // volatile_status_two
	output logic [7:0] CONFIG_TWO_O, // volatile_config_two
	output logic VOL_TARGET_O, // next register write goes to volatile copies
	output logic [7:0] PATTERN_NV_O, // non-volatile learning_pattern
	output logic [7:0] PATTERN_VOL_O // volatile learning_pattern
);
	localparam int PROG_CYCLES = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	if (PROG_TIME_NS < 1)
	begin : g_check
		$error("program time must be at least one ns");
	end

	typedef struct packed {
		fwec_state_t st;
		logic quad;
		logic [3:0] clks;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [2:0] out_pos;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic [7:0] sr1;
		logic [7:0] sr2;
		logic [7:0] cr2;
		logic vol_target;
		logic [7:0] pat_nv;
		logic [7:0] pat_vol;
		logic [7:0] prog_byte;
		logic prog_busy;
		logic [CNT_W-1:0] prog_cnt;
		logic cs_prev;
		logic sck_prev;
	} fwec_core_t;

	fwec_core_t q;
	fwec_core_t next_q;
	logic [5:0] pins_s;
	logic cs_s;
	logic sck_s;
	logic [3:0] io_s;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic exec_now;
	logic [3:0] byte_clks;
	logic [3:0] clks_inc;
	logic [7:0] shift_in;

	////////////////////////////////////////////////////////////////
	// pin sampling; edges found on the synchronised copies only
	fwec_sync #(
		.W(6),
		.RESET_VAL(6'h20) // idle levels: chip select high, mode 0 clock low, so no false edge after reset
	) u_sync (
		.clk_i(MCLK_I),
		.rst_i(RESET_I),
		.d_i({CS_N_I, SCK_I, IO_I}),
		.q_o(pins_s)
	);

	assign cs_s = pins_s[5];
	assign sck_s = pins_s[4];
	assign io_s = pins_s[3:0];
	assign sck_rise = sck_s & ~q.sck_prev;
	assign sck_fall = ~sck_s & q.sck_prev;
	assign cs_fall = ~cs_s & q.cs_prev;
	assign cs_rise = cs_s & ~q.cs_prev;
	assign exec_now = cs_rise && (q.st == ST_EXEC);
	assign byte_clks = q.quad ? QUAD_CLKS : SINGLE_CLKS;
	assign clks_inc = q.clks + 4'h1;
	// high nibble arrives first in four-line mode
	assign shift_in = q.quad ? {q.shift[3:0], io_s} : {q.shift[6:0], io_s[0]};

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		next_q = q;
		next_q.sck_prev = sck_s;
		next_q.cs_prev = cs_s;
		if (cs_fall)
		begin
			next_q.st = ST_CMD;
			next_q.quad = FOUR_LINE_MODE_I;
			next_q.clks = '0;
			next_q.shift = '0;
			next_q.out_pos = '0;
		end
		else if (cs_s)
		begin
			next_q.st = ST_IDLE;
			next_q.io_oe = '0;
			next_q.io_out = '0;
		end
		else if (sck_rise)
		begin
			case (q.st)
				ST_CMD:
				begin
					next_q.shift = shift_in;
					next_q.clks = clks_inc;
					if (clks_inc == byte_clks)
					begin
						next_q.opcode = shift_in;
						next_q.clks = '0;
						case (shift_in)
							OP_LATCH_SET, OP_LATCH_CLEAR, OP_VOL_DIRECT, OP_STATUS_CLEAR, OP_ENTER_WIDE:
								next_q.st = ST_EXEC;
							OP_PAT_NV_PROGRAM, OP_PAT_VOL_WRITE:
								next_q.st = ST_ARG;
							OP_PAT_READ:
								next_q.st = ST_RD_DUMMY;
							default:
								next_q.st = ST_DROP;
						endcase
					end
				end
				ST_ARG:
				begin
					next_q.shift = shift_in;
					next_q.clks = clks_inc;
					if (clks_inc == byte_clks)
					begin
						next_q.st = ST_EXEC;
					end
				end
				// lines are not looked at during the dummy clock
				ST_RD_DUMMY:
					next_q.st = ST_RD_OUT;
				// any clock past the last bit cancels the command
				ST_EXEC:
					next_q.st = ST_DROP;
				default:
					next_q.st = q.st;
			endcase
		end
		else if (sck_fall && (q.st == ST_RD_OUT))
		begin
			// pattern repeats for as long as the host keeps clocking
			next_q.out_pos = q.out_pos + 3'h1;
			if (q.quad)
			begin
				next_q.io_out = q.out_pos[0] ? q.pat_vol[3:0] : q.pat_vol[7:4];
				next_q.io_oe = LANES_ALL;
			end
			else
			begin
				next_q.io_out = '0;
				next_q.io_out[OUT_LANE] = q.pat_vol[3'h7 - q.out_pos];
				next_q.io_oe = '0;
				next_q.io_oe[OUT_LANE] = 1'b1;
			end
		end

		// command execution on chip select rising at a byte boundary
		if (exec_now)
		begin
			case (q.opcode)
				OP_LATCH_SET:
				begin
					next_q.sr1[WPL_BIT] = 1'b1;
					next_q.vol_target = 1'b0;
				end
				OP_LATCH_CLEAR:
					if (!q.sr1[WIP_BIT])
					begin
						next_q.sr1[WPL_BIT] = 1'b0;
					end
				OP_VOL_DIRECT:
					next_q.vol_target = 1'b1;
				OP_STATUS_CLEAR:
				begin
					next_q.sr1[WIP_BIT] = 1'b0;
					next_q.sr1[WPL_BIT] = 1'b0;
					next_q.sr2[PERR_BIT] = 1'b0;
					next_q.sr2[EERR_BIT] = 1'b0;
				end
				OP_PAT_NV_PROGRAM:
					if (q.sr1[WPL_BIT] && !q.sr1[WIP_BIT])
					begin
						next_q.prog_busy = 1'b1;
						next_q.sr1[WIP_BIT] = 1'b1;
						next_q.prog_byte = q.shift;
						next_q.prog_cnt = CNT_W'(PROG_CYCLES - 1);
					end
				OP_PAT_VOL_WRITE:
					if (q.sr1[WPL_BIT] && !q.sr1[WIP_BIT])
					begin
						next_q.pat_vol = q.shift;
					end
				OP_ENTER_WIDE:
					next_q.cr2[ALEN_BIT] = 1'b1;
				default:
					next_q.opcode = q.opcode;
			endcase
		end

		// self-timed non-volatile pattern program
		if (q.prog_busy)
		begin
			if (q.prog_cnt == '0)
			begin
				next_q.prog_busy = 1'b0;
				next_q.sr1[WPL_BIT] = 1'b0;
				if (PROG_FAIL_I)
				begin
					// failure leaves the device busy until status-clear
					next_q.sr2[PERR_BIT] = 1'b1;
				end
				else
				begin
					next_q.pat_nv = q.prog_byte;
					next_q.sr1[WIP_BIT] = 1'b0;
				end
			end
			else
			begin
				next_q.prog_cnt = q.prog_cnt - CNT_W'(1);
			end
		end

		// neighbouring logic; applied last so its pulses beat a same-cycle command, whether they set or clear
		if (WIDE_ADDR_CLEAR_I)
		begin
			next_q.cr2[ALEN_BIT] = 1'b0;
		end
		if (SOFT_RESET_I)
		begin
			next_q.cr2[ALEN_BIT] = NV_ADDR_LEN_I;
		end
		if (REG_WRITE_DONE_I)
		begin
			next_q.vol_target = 1'b0;
			next_q.sr1[WPL_BIT] = 1'b0;
		end
		if (REG_WRITE_FAIL_I)
		begin
			next_q.sr2[PERR_BIT] = 1'b1;
			next_q.sr1[WIP_BIT] = 1'b1;
		end
		if (ERASE_FAIL_I)
		begin
			next_q.sr2[EERR_BIT] = 1'b1;
			next_q.sr1[WIP_BIT] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// state register; the strap is taken in a clocked reset
	always_ff @(posedge MCLK_I)
	begin
		if (RESET_I)
		begin
			q <= '0;
			q.cs_prev <= 1'b1;
			q.cr2[ALEN_BIT] <= NV_ADDR_LEN_I;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign IO_O = q.io_out;
	assign IO_OE_O = q.io_oe;
	assign STATUS_ONE_O = q.sr1;
	assign STATUS_TWO_O = q.sr2;
	assign CONFIG_TWO_O = q.cr2;
	assign VOL_TARGET_O = q.vol_target;
	assign PATTERN_NV_O = q.pat_nv;
	assign PATTERN_VOL_O = q.pat_vol;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);

	logic quiet;
	assign quiet = !REG_WRITE_DONE_I && !REG_WRITE_FAIL_I && !ERASE_FAIL_I && !(q.prog_busy && ~|q.prog_cnt);

	latch_set_a: assert property (exec_now && q.opcode == OP_LATCH_SET && quiet |=> q.sr1[WPL_BIT])
		else $error("latch-set did not set the latch");
	latch_clear_a: assert property (exec_now && q.opcode == OP_LATCH_CLEAR && !q.sr1[WIP_BIT] && quiet
		|=> !q.sr1[WPL_BIT])
		else $error("latch-clear did not clear the latch");
	clear_busy_a: assert property (exec_now && q.opcode == OP_LATCH_CLEAR && q.sr1[WIP_BIT]
		&& q.sr1[WPL_BIT] && quiet |=> q.sr1[WPL_BIT])
		else $error("latch-clear acted while busy");
	vol_direct_a: assert property (exec_now && q.opcode == OP_VOL_DIRECT && quiet
		|=> q.vol_target && $stable(q.sr1))
		else $error("volatile-direct misbehaved");
	status_clear_a: assert property (exec_now && q.opcode == OP_STATUS_CLEAR && quiet
		|=> !q.sr1[WIP_BIT] && !q.sr1[WPL_BIT] && !q.sr2[PERR_BIT] && !q.sr2[EERR_BIT])
		else $error("status-clear left a flag set");
	dropped_cmd_a: assert property (cs_rise && q.st == ST_DROP && quiet && !SOFT_RESET_I && !WIDE_ADDR_CLEAR_I
		|=> $stable(q.sr1) && $stable(q.cr2) && $stable(q.pat_vol))
		else $error("misframed command took effect");
	prog_start_a: assert property (exec_now && q.opcode == OP_PAT_NV_PROGRAM && q.sr1[WPL_BIT]
		&& !q.sr1[WIP_BIT] && quiet |=> q.prog_busy && q.sr1[WIP_BIT])
		else $error("pattern program did not start");
	prog_end_a: assert property (q.prog_busy && q.prog_cnt == '0 && !REG_WRITE_FAIL_I && !ERASE_FAIL_I
		&& !exec_now |=> !q.sr1[WPL_BIT] && (q.sr1[WIP_BIT] == $past(PROG_FAIL_I)))
		else $error("pattern program end wrong");
	no_latch_a: assert property (exec_now && q.opcode == OP_PAT_VOL_WRITE && !q.sr1[WPL_BIT]
		|=> $stable(q.pat_vol))
		else $error("pattern written without latch");
	vol_write_a: assert property (exec_now && q.opcode == OP_PAT_VOL_WRITE && q.sr1[WPL_BIT]
		&& !q.sr1[WIP_BIT] |=> q.pat_vol == $past(q.shift))
		else $error("volatile pattern not updated");
	dummy_quiet_a: assert property (q.st == ST_RD_DUMMY |-> q.io_oe == '0)
		else $error("lines driven in dummy clock");
	drive_scope_a: assert property (q.io_oe != '0 |-> q.st == ST_RD_OUT && !q.cs_prev)
		else $error("lines driven outside pattern read");
	wide_set_a: assert property (exec_now && q.opcode == OP_ENTER_WIDE && !WIDE_ADDR_CLEAR_I && !SOFT_RESET_I
		|=> q.cr2[ALEN_BIT])
		else $error("enter-wide did not set length bit");
	wide_clear_a: assert property (WIDE_ADDR_CLEAR_I && !SOFT_RESET_I |=> !q.cr2[ALEN_BIT])
		else $error("length bit not cleared");
	fail_busy_a: assert property (REG_WRITE_FAIL_I |=> q.sr1[WIP_BIT] && q.sr2[PERR_BIT])
		else $error("failed write not held busy");
	quad_nibble_a: assert property (q.st == ST_CMD && q.quad && sck_rise && !cs_fall && !cs_s
		|=> q.shift[3:0] == $past(io_s))
		else $error("nibble taken wrongly");

	cover_read_c: cover property (q.st == ST_RD_OUT && sck_fall);
	cover_prog_c: cover property (q.prog_busy && q.prog_cnt == '0);
	cover_quad_c: cover property (exec_now && q.quad);
endmodule

// File: testbench/fwec_host.sv
// host serial controller model for the housekeeping command link
`timescale 1ns/1ps
module fwec_host (
	input wire logic clk_i, // core clock, paces the link only
	input wire logic [3:0] io_i, // resolved data lines
	output logic sck_o, // serial clock, mode 0, still outside frames
	output logic cs_n_o, // chip select, active low
	output logic [3:0] io_o // data lines as driven by the host
);
	// 64 ns link period keeps well under the top serial rate
	localparam int HALF = 8;
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h5;
	end
	task automatic wait_mclk(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// nclk clocks of w msb first, then if nrd > 0 one dummy clock and nrd bytes read back
	task automatic frame(input logic [15:0] w, input int nclk, input bit quad, input int nrd,
		output logic [15:0] rd);
		rd = '0;
		wait_mclk(HALF);
		cs_n_o = 1'b0;
		for (int i = 0; i < nclk; i++)
		begin
			if (quad)
				io_o = w[15:12];
			else
				io_o = {~io_o[3:1], w[15]};
			w = quad ? {w[11:0], 4'h0} : {w[14:0], 1'b0};
			wait_mclk(HALF);
			sck_o = 1'b1;
			wait_mclk(HALF);
			sck_o = 1'b0;
		end
		for (int i = 0; i < (nrd == 0 ? 0 : 1 + nrd * (quad ? 2 : 8)); i++)
		begin
			// released lines toggle so a stale level never passes for data
			io_o = ~io_o;
			wait_mclk(HALF);
			if (i > 0)
				rd = quad ? {rd[11:0], io_i} : {rd[14:0], io_i[1]};
			sck_o = 1'b1;
			wait_mclk(HALF);
			sck_o = 1'b0;
		end
		wait_mclk(HALF);
		cs_n_o = 1'b1;
		io_o = ~io_o;
		wait_mclk(3 * HALF);
	endtask
endmodule

// File: testbench/fwec_top_bench.sv
// self-checking bench for the housekeeping command decoder
`timescale 1ns/1ps
module fwec_top_bench;
	import fwec_pkg::*;
	logic clk;
	logic rst;
	logic quad;
	logic nv_len;
	logic pfail;
	logic [4:0] pls;
	logic [15:0] rd;
	int bad_count = 0;
	int n_compared = 0;
	wire logic sck;
	wire logic cs_n;
	wire logic [3:0] hio;
	wire logic [3:0] dio;
	wire logic [3:0] doe;
	wire logic [3:0] io;
	wire logic [7:0] s1;
	wire logic [7:0] s2;
	wire logic [7:0] cfg;
	wire logic vtgt;
	wire logic [7:0] pnv;
	wire logic [7:0] pvol;
	assign io = (doe & dio) | (~doe & hio);
	fwec_top #(.PROG_TIME_NS(2000)) uut (
		.MCLK_I(clk),
		.RESET_I(rst),
		.SCK_I(sck),
		.CS_N_I(cs_n),
		.IO_I(io),
		.IO_O(dio),
		.IO_OE_O(doe),
		.FOUR_LINE_MODE_I(quad),
		.NV_ADDR_LEN_I(nv_len),
		.SOFT_RESET_I(pls[0]),
		.WIDE_ADDR_CLEAR_I(pls[1]),
		.REG_WRITE_DONE_I(pls[2]),
		.REG_WRITE_FAIL_I(pls[3]),
		.ERASE_FAIL_I(pls[4]),
		.PROG_FAIL_I(pfail),
		.STATUS_ONE_O(s1),
		.STATUS_TWO_O(s2),
		.CONFIG_TWO_O(cfg),
		.VOL_TARGET_O(vtgt),
		.PATTERN_NV_O(pnv),
		.PATTERN_VOL_O(pvol)
	);
	fwec_host host (.clk_i(clk), .io_i(io), .sck_o(sck), .cs_n_o(cs_n), .io_o(hio));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask
	task wrap_up;
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task cmd(input logic [15:0] w, input int nclk);
		host.frame(w, nclk, quad, 0, rd);
	endtask
	task pulse(input int k);
		pls[k] = 1'b1;
		@(negedge clk);
		pls[k] = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task wait_idle;
		for (int k = 0; k < 1000 && s1[0] !== 1'b0; k++)
			@(negedge clk);
	endtask
	// watchdog: the whole sequence needs well under 10000 cycles
	initial
	begin
		repeat (40000) @(negedge clk);
		bad_count++;
		wrap_up;
	end
	initial
	begin
		rst = 1'b1;
		quad = 1'b0;
		nv_len = 1'b0;
		pfail = 1'b0;
		pls = '0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check("addr len", cfg, 8'h00);
		cmd(16'h0600, 8);
		check("status one", s1, 8'h02);
		check("vol target", vtgt, 1'b0);
		cmd(16'h5000, 8);
		check("status one", s1, 8'h02);
		check("vol target", vtgt, 1'b1);
		pulse(2);
		check("vol target", vtgt, 1'b0);
		cmd(16'h0600, 9);
		check("status one", s1, 8'h00);
		cmd(16'h0600, 5);
		check("status one", s1, 8'h00);
		cmd(16'h4AA5, 16);
		check("pattern vol", pvol, 8'h00);
		cmd(16'h0600, 8);
		cmd(16'hFF00, 8);
		check("status one", s1, 8'h02);
		cmd(16'h4AA5, 16);
		check("pattern vol", pvol, 8'hA5);
		host.frame(16'h4100, 8, 1'b0, 2, rd);
		check("pattern read", rd, 16'hA5A5);
		cmd(16'h0400, 8);
		check("status one", s1, 8'h00);
		quad = 1'b1;
		cmd(16'h0600, 2);
		cmd(16'h4A3C, 4);
		check("pattern vol", pvol, 8'h3C);
		host.frame(16'h4100, 2, 1'b1, 2, rd);
		check("quad read", rd, 16'h3C3C);
		quad = 1'b0;
		cmd(16'h0600, 8);
		cmd(16'h435A, 17);
		check("pattern nv", pnv, 8'h00);
		check("status one", s1, 8'h02);
		cmd(16'h435A, 16);
		check("status one", s1, 8'h03);
		cmd(16'h0400, 8);
		check("status one", s1, 8'h03);
		wait_idle;
		check("status one", s1, 8'h00);
		check("pattern nv", pnv, 8'h5A);
		pfail = 1'b1;
		cmd(16'h0600, 8);
		cmd(16'h4377, 16);
		repeat (600) @(negedge clk);
		check("status two", s2, 8'h20);
		check("status one", s1, 8'h01);
		pfail = 1'b0;
		cmd(16'h3000, 8);
		check("status one", s1, 8'h00);
		check("status two", s2, 8'h00);
		cmd(16'h0600, 8);
		pulse(4);
		pulse(3);
		check("status two", s2, 8'h60);
		check("status one", s1, 8'h03);
		cmd(16'h3000, 8);
		check("status one", s1, 8'h00);
		check("status two", s2, 8'h00);
		cmd(16'hB700, 8);
		check("addr len", cfg, 8'h01);
		pulse(1);
		check("addr len", cfg, 8'h00);
		cmd(16'hB700, 8);
		pulse(0);
		check("addr len", cfg, 8'h00);
		nv_len = 1'b1;
		pulse(0);
		check("addr len", cfg, 8'h01);
		pulse(1);
		check("addr len", cfg, 8'h00);
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check("addr len", cfg, 8'h01);
		wrap_up;
	end
endmodule
